// ===== logic/chd_regs.sv
// channel-2 diagnostic setup and conversion result registers
// assumes serial link decoding upstream on clk_sys; all inputs synchronous
`timescale 1ns/1ps
`include "chd_defs.svh"
module chd_regs import chd_pkg::*; #(
    parameter int BLANK0_CYC = `CHD_US_CYC(`CHD_BLANK0_US),
    parameter int BLANK1_CYC = `CHD_US_CYC(`CHD_BLANK1_US),
    parameter int BLANK2_CYC = `CHD_US_CYC(`CHD_BLANK2_US),
    parameter int BLANK3_CYC = `CHD_US_CYC(`CHD_BLANK3_US)
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register access
    input wire chd_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    // channel status
    input wire logic chan_on,
    input wire logic chan_fault,
    input wire logic diag_raw,
    // conversions
    input wire logic cur_done,
    input wire logic [9:0] cur_value,
    input wire logic temp_done,
    input wire logic [9:0] temp_value,
    input wire logic volt_done,
    input wire logic [9:0] volt_value,
    // analog controls and diagnostic fault flag
    output chd_ctrl_t ctrl,
    output logic diag_fault
);
    logic [15:0] diag_reg, diag_next;
    logic [10:0] cur_reg, temp_reg, volt_reg;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg;
    chd_ctrl_t ctrl_reg;
    chd_blank_t bst_reg;
    logic [16:0] bcnt_reg;
    logic [16:0] blank_len;
    logic fault_reg;
    wire sel_diag = req.addr == `CHD_ADDR_DIAG;
    wire sel_cur = req.addr == `CHD_ADDR_CUR;
    wire sel_temp = req.addr == `CHD_ADDR_TEMP;
    wire sel_volt = req.addr == `CHD_ADDR_VOLT;
    wire wr_diag = req.wr && sel_diag;
    wire rd_cur = req.rd && sel_cur;
    wire rd_temp = req.rd && sel_temp;
    wire rd_volt = req.rd && sel_volt;
    wire off_blocked = chan_on || chan_fault;
    wire [15:0] wmasked = req.wdata & `CHD_DIAG_WMASK;
    // off-state checks refused while on or faulted [RQ7]
    wire oloff_new = wmasked[`CHD_BIT_OLOFF] && !off_blocked;
    wire svbb_new = wmasked[`CHD_BIT_SVBB] && !off_blocked;
    wire [1:0] blank_sel = diag_reg[`CHD_BLANK_HI:`CHD_BLANK_LO];
    assign blank_len = (blank_sel == 2'h0) ? 17'(BLANK0_CYC) :
                       (blank_sel == 2'h1) ? 17'(BLANK1_CYC) :
                       (blank_sel == 2'h2) ? 17'(BLANK2_CYC) :
                       17'(BLANK3_CYC);
    wire checks_on = diag_reg[`CHD_BIT_OLON] || diag_reg[`CHD_BIT_OLOFF]
                     || diag_reg[`CHD_BIT_SVBB];
    always_comb begin
        diag_next = diag_reg;
        if (wr_diag) begin
            diag_next = {wmasked[15:5], oloff_new, svbb_new, wmasked[2:0]};
        end
        // a fault or switch-on drops active off-state checks [RQ7]
        if (off_blocked) begin
            diag_next[`CHD_BIT_OLOFF] = 1'b0;
            diag_next[`CHD_BIT_SVBB] = 1'b0;
        end
    end
    // reserved bits read zero, unmapped reads return zero [RQ16]
    assign rdata_next = sel_diag ? diag_reg :
                        sel_cur ? {5'h00, cur_reg} :
                        sel_temp ? {5'h00, temp_reg} :
                        sel_volt ? {5'h00, volt_reg} : 16'h0000;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            diag_reg <= `CHD_DIAG_RESET; // [RQ9] [RQ14]
        end else if (clk_en) begin
            diag_reg <= diag_next;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else if (clk_en) begin
            rvalid_reg <= req.rd;
            if (req.rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end
    // result words: new conversion wins over read clear [RQ13] [RQ15]
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cur_reg <= 11'h000; // [RQ10]
            temp_reg <= 11'h000;
            volt_reg <= 11'h000;
        end else if (clk_en) begin
            if (cur_done && !diag_reg[`CHD_BIT_IOFF]) begin
                cur_reg <= {1'b1, cur_value}; // [RQ10]
            end else if (rd_cur) begin
                cur_reg[`CHD_BIT_FRESH] <= 1'b0;
            end
            if (temp_done && !diag_reg[`CHD_BIT_TOFF]) begin
                temp_reg <= {1'b1, temp_value}; // [RQ11]
            end else if (rd_temp) begin
                temp_reg[`CHD_BIT_FRESH] <= 1'b0;
            end
            if (volt_done && !diag_reg[`CHD_BIT_VOFF]) begin
                volt_reg <= {1'b1, volt_value}; // [RQ12]
            end else if (rd_volt) begin
                volt_reg[`CHD_BIT_FRESH] <= 1'b0;
            end
        end
    end
    // analog controls follow the setup word [RQ1] [RQ4] [RQ5] [RQ6]
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg <= '0;
            ctrl_reg.slew_sel <= 2'h2;
            ctrl_reg.volt_off <= 1'b1;
            ctrl_reg.temp_off <= 1'b1;
        end else if (clk_en) begin
            ctrl_reg.precise_on <= diag_reg[`CHD_BIT_OLON]; // [RQ1]
            ctrl_reg.pullup_sel <= diag_reg[`CHD_PU_HI:`CHD_PU_LO]; // [RQ4]
            ctrl_reg.pullup_on <= diag_reg[`CHD_BIT_OLOFF]; // [RQ5]
            ctrl_reg.pulldown_on <= diag_reg[`CHD_BIT_SVBB]; // [RQ6]
            ctrl_reg.latch_off <= diag_reg[`CHD_BIT_LATCH]; // [RQ8]
            ctrl_reg.slew_sel <= diag_reg[`CHD_SLEW_HI:`CHD_SLEW_LO]; // [RQ9]
            ctrl_reg.volt_off <= diag_reg[`CHD_BIT_VOFF]; // [RQ14]
            ctrl_reg.temp_off <= diag_reg[`CHD_BIT_TOFF];
            ctrl_reg.cur_off <= diag_reg[`CHD_BIT_IOFF];
        end
    end
    // fault registered only after the raw condition outlasts blanking [RQ3]
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bst_reg <= CHD_IDLE;
            bcnt_reg <= 17'h00000;
            fault_reg <= 1'b0;
        end else if (clk_en) begin
            case (bst_reg)
                CHD_IDLE: begin
                    fault_reg <= 1'b0;
                    bcnt_reg <= 17'h00001;
                    if (diag_raw && checks_on) begin
                        bst_reg <= CHD_BLANK;
                    end
                end
                CHD_BLANK: begin
                    if (!diag_raw || !checks_on) begin
                        bst_reg <= CHD_IDLE;
                    end else if (bcnt_reg >= blank_len) begin
                        bst_reg <= CHD_FAULT;
                        fault_reg <= 1'b1;
                    end else begin
                        bcnt_reg <= bcnt_reg + 17'h00001;
                    end
                end
                CHD_FAULT: begin
                    if (!diag_raw || !checks_on) begin
                        bst_reg <= CHD_IDLE;
                        fault_reg <= 1'b0;
                    end
                end
                default: bst_reg <= CHD_IDLE;
            endcase
        end
    end
    assign rdata = rdata_reg;
    assign rvalid = rvalid_reg;
    assign ctrl = ctrl_reg;
    assign diag_fault = fault_reg;

    chk_fresh_set: assert property ( // [RQ13]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && cur_done && !diag_reg[`CHD_BIT_IOFF]
        |=> cur_reg[`CHD_BIT_FRESH] && cur_reg[9:0] == $past(cur_value))
        else $error("current result not captured");
    chk_fresh_clear: assert property ( // [RQ15]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && rd_temp && !temp_done |=> !temp_reg[`CHD_BIT_FRESH])
        else $error("temp fresh not cleared by read");
    chk_reserved_zero: assert property ( // [RQ16]
        @(posedge clk_sys) disable iff (sys_rst)
        rvalid_reg && !$past(sel_diag) |-> rdata_reg[15:11] == 5'h00)
        else $error("reserved result bits nonzero");
    chk_offcheck_block: assert property ( // [RQ7]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en && off_blocked |=> !diag_reg[`CHD_BIT_OLOFF]
        && !diag_reg[`CHD_BIT_SVBB])
        else $error("off-state check set while blocked");
    chk_pullup_follow: assert property ( // [RQ5]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en ##1 $stable(diag_reg)
        |-> ctrl_reg.pullup_on == diag_reg[`CHD_BIT_OLOFF]
        && ctrl_reg.pulldown_on == diag_reg[`CHD_BIT_SVBB])
        else $error("pull controls not following setup");
    chk_precise_follow: assert property ( // [RQ1]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en |=> ctrl_reg.precise_on == $past(diag_reg[`CHD_BIT_OLON]))
        else $error("precise mode not following setup");
    chk_pullsel_follow: assert property ( // [RQ4]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en |=> ctrl_reg.pullup_sel
        == $past(diag_reg[`CHD_PU_HI:`CHD_PU_LO]))
        else $error("pull-up strength not following setup");
    chk_blank_fault: assert property ( // [RQ3]
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(fault_reg) |-> $past(bst_reg) == CHD_BLANK
        && $past(bcnt_reg) >= $past(blank_len))
        else $error("fault before blanking ended");
    chk_slew_reset: assert property ( // [RQ9]
        @(posedge clk_sys)
        $fell(sys_rst) |-> diag_reg[`CHD_SLEW_HI:`CHD_SLEW_LO] == 2'h2
        && diag_reg[`CHD_BIT_VOFF])
        else $error("setup reset value wrong");
    chk_slew_follow: assert property ( // [RQ9]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en |=> ctrl_reg.slew_sel
        == $past(diag_reg[`CHD_SLEW_HI:`CHD_SLEW_LO]))
        else $error("slew select not following setup");
    chk_latch_follow: assert property ( // [RQ8]
        @(posedge clk_sys) disable iff (sys_rst)
        clk_en |=> ctrl_reg.latch_off == $past(diag_reg[`CHD_BIT_LATCH]))
        else $error("latch select not following");
endmodule

// ===== logic/chd_defs.svh
// constants for the channel-2 diagnostic and conversion register slice
// assumes a register access port decoded from the serial link upstream
// Summary of operation
// RQ1: precise on-state check lowers ratio, raises resistance
// RQ2: host avoids precise check during fault/high current
// RQ3: open-load/short faults register after selected blanking
// RQ4: two-bit field selects off-state pull-up current
// RQ5: off-state open-load enable connects output pull-up
// RQ6: supply-short check enable connects output pull-down
// RQ7: off-state checks refused while on or faulted
// RQ8: latch select: auto retry or hold off
// RQ9: slew field selects rate, resets to two
// RQ10: current result bits 9-0, read-only, reset zero
// RQ11: temperature result bits 9-0, read-only
// RQ12: voltage result bits 9-0, read-only
// RQ13: bit 10 flags conversion newer than last read
// RQ14: measurement disables, voltage/temp reset one
// RQ15: reading clears freshness; new conversion sets it
// RQ16: result bits 15-11 read zero; writes ignored
`ifndef CHD_DEFS_SVH
`define CHD_DEFS_SVH
`define CHD_ADDR_DIAG 5'h18
`define CHD_ADDR_CUR 5'h19
`define CHD_ADDR_TEMP 5'h1a
`define CHD_ADDR_VOLT 5'h1b
`define CHD_DIAG_RESET 16'hc002
`define CHD_DIAG_WMASK 16'he7ff
`define CHD_BIT_VOFF 15
`define CHD_BIT_TOFF 14
`define CHD_BIT_IOFF 13
`define CHD_BIT_OLON 9
`define CHD_BLANK_HI 8
`define CHD_BLANK_LO 7
`define CHD_PU_HI 6
`define CHD_PU_LO 5
`define CHD_BIT_OLOFF 4
`define CHD_BIT_SVBB 3
`define CHD_BIT_LATCH 2
`define CHD_SLEW_HI 1
`define CHD_SLEW_LO 0
`define CHD_BIT_FRESH 10
`define CHD_CLK_HZ 20000000
// blanking times in microseconds, cycle counts derived from clock rate
`define CHD_BLANK0_US 400
`define CHD_BLANK1_US 1000
`define CHD_BLANK2_US 2000
`define CHD_BLANK3_US 4000
`define CHD_US_CYC(us) ((us) * (`CHD_CLK_HZ / 1000000))
`endif

// ===== logic/chd_pkg.sv
// types for the channel-2 diagnostic register slice
// assumes chd_defs.svh is on the include path
package chd_pkg;
    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } chd_req_t;
    typedef struct packed {
        logic precise_on;
        logic [1:0] pullup_sel;
        logic pullup_on;
        logic pulldown_on;
        logic latch_off;
        logic [1:0] slew_sel;
        logic volt_off;
        logic temp_off;
        logic cur_off;
    } chd_ctrl_t;
    typedef enum logic [1:0] {
        CHD_IDLE,
        CHD_BLANK,
        CHD_FAULT
    } chd_blank_t;
endpackage

// ===== tb/chd_host.sv
// host-side register master model for the channel-2 slice
// assumes strobes are taken on the rising clk_sys edge
`timescale 1ns/1ps
module chd_host import chd_pkg::*; (
    // clock
    input wire logic clk_sys,
    // register request
    output chd_req_t req
);
    initial req = '0;
    // one-cycle strobe; write data shows inverted once released
    // bench avoids precise check under fault; writes off-state checks while on or faulted to see them refused
    task automatic xfer(input logic [4:0] a, input logic [15:0] d,
            input logic w);
        @(negedge clk_sys);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(negedge clk_sys);
        req <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the channel-2 register slice
// assumes chd_defs.svh on the include path; blank counts 4, 8, 16, 32
`timescale 1ns/1ps
`include "chd_defs.svh"
module tb import chd_pkg::*; ;
    logic clk_sys = 0, sys_rst = 1, clk_en = 1;
    logic chan_on = 0, chan_fault = 0, diag_raw = 0;
    logic [2:0] dn = 3'h0;
    logic [9:0] v [3] = '{10'h000, 10'h000, 10'h000};
    logic [15:0] q [$];
    logic [15:0] rdata;
    logic rvalid, diag_fault;
    chd_ctrl_t ctrl;
    chd_req_t req;
    int fails = 0, n_compared = 0, n;
    logic n_ok;
    logic [15:0] e_mon;
    logic [31:0] seed = 32'd84714;
    always #25 clk_sys = ~clk_sys;
    chd_host i_host (.clk_sys(clk_sys), .req(req));
    chd_regs #(.BLANK0_CYC(4), .BLANK1_CYC(8), .BLANK2_CYC(16),
        .BLANK3_CYC(32)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .clk_en(clk_en), .req(req), .rdata(rdata), .rvalid(rvalid),
        .chan_on(chan_on), .chan_fault(chan_fault), .diag_raw(diag_raw),
        .cur_done(dn[0]), .cur_value(v[0]), .temp_done(dn[1]),
        .temp_value(v[1]), .volt_done(dn[2]), .volt_value(v[2]),
        .ctrl(ctrl), .diag_fault(diag_fault));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string nm, input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        q.push_back(e);
        i_host.xfer(a, 16'h0000, 1'b0);
    endtask
    task automatic rst(input int c);
        sys_rst <= 1'b1;
        repeat (c) @(negedge clk_sys);
        sys_rst <= 1'b0;
    endtask
    task automatic conv();
        @(negedge clk_sys);
        for (int i = 0; i < 3; i++) v[i] <= 10'(rnd());
        dn <= 3'h7;
        @(negedge clk_sys);
        dn <= 3'h0;
    endtask
    // read data monitor against oldest expectation
    always @(negedge clk_sys) begin
        if (rvalid === 1'b1) begin
            check("rdata_due", 16'(q.size() != 0), 16'h0001);
            e_mon = q.size() ? q.pop_front() : 16'h0000;
            check("rdata", rdata, e_mon);
        end
    end
    initial begin
        #(50 * 4000);
        fails++;
        test_done();
    end
    initial begin
        rst(12);
        rd(`CHD_ADDR_DIAG, 16'hc002);
        rd(`CHD_ADDR_CUR, 16'h0000);
        rd(`CHD_ADDR_TEMP, 16'h0000);
        rd(`CHD_ADDR_VOLT, 16'h0000);
        rd(5'h03, 16'h0000);
        check("ctrl", 16'(ctrl), 16'h0016);
        conv();
        rd(`CHD_ADDR_CUR, {6'h01, v[0]});
        rd(`CHD_ADDR_CUR, {6'h00, v[0]});
        rd(`CHD_ADDR_TEMP, 16'h0000);
        i_host.xfer(`CHD_ADDR_DIAG, 16'hffff, 1'b1);
        rd(`CHD_ADDR_DIAG, 16'he7ff);
        check("ctrl", 16'(ctrl), 16'h07ff);
        i_host.xfer(`CHD_ADDR_CUR, 16'hffff, 1'b1);
        rd(`CHD_ADDR_CUR, {6'h00, v[0]});
        for (int k = 0; k < 2; k++) begin
            chan_on <= (k == 0);
            chan_fault <= (k == 1);
            i_host.xfer(`CHD_ADDR_DIAG, 16'h1dff, 1'b1);
            rd(`CHD_ADDR_DIAG, 16'h05e7);
        end
        chan_on <= 1'b0;
        chan_fault <= 1'b0;
        conv();
        for (int i = 0; i < 3; i++) begin
            rd(5'(`CHD_ADDR_CUR + i), {6'h01, v[i]});
            rd(5'(`CHD_ADDR_CUR + i), {6'h00, v[i]});
        end
        for (int b = 0; b < 4; b++) begin
            rst(2);
            i_host.xfer(`CHD_ADDR_DIAG, 16'(b << 7) | 16'h0010, 1'b1);
            diag_raw <= 1'b1;
            n = 0;
            while (diag_fault !== 1'b1 && n < 80) begin
                @(negedge clk_sys);
                n++;
            end
            diag_raw <= 1'b0;
            n_ok = n >= (4 << b) && n <= (4 << b) + 4;
            check("blank", 16'(n_ok), 16'h0001);
        end
        clk_en <= 1'b0;
        i_host.xfer(`CHD_ADDR_CUR, 16'h0000, 1'b0);
        clk_en <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check("queue", 16'(q.size()), 16'h0000);
        test_done();
    end
endmodule
